// ==== shared/acc_pkg.sv ====
package acc_pkg;

  // Register bus widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register offsets
  localparam logic [11:0] OFF_MIS    = 12'h000;
  localparam logic [11:0] OFF_RIS    = 12'h004;
  localparam logic [11:0] OFF_INTEN  = 12'h008;
  localparam logic [11:0] OFF_REFCTL = 12'h010;
  localparam logic [11:0] OFF_STAT   = 12'h020;
  localparam logic [11:0] OFF_CTL    = 12'h024;

  // Interrupt bit position in status, clear and enable registers
  localparam int IRQ_BIT = 0;

  // Comparator control register fields
  localparam int CTL_INV_BIT    = 1;
  localparam int CTL_ISEN_LSB   = 2;
  localparam int CTL_ISLVAL_BIT = 4;
  localparam int CTL_TSEN_LSB   = 5;
  localparam int CTL_TSLVAL_BIT = 7;
  localparam int CTL_SRC_LSB    = 9;
  localparam int CTL_TEN_BIT    = 11;

  // Reference control register fields
  localparam int REF_EN_BIT  = 9;
  localparam int REF_RNG_BIT = 8;
  localparam int REF_TAP_LSB = 0;
  localparam int TAP_W       = 4;

  // Comparator status register field
  localparam int STAT_OUTPUT_VALUE_BIT_BIT = 1;

  // Reset values
  localparam logic [31:0] CTL_RST    = 32'h0000_0000;
  localparam logic [31:0] REFCTL_RST = 32'h0000_0000;
  localparam logic        INTEN_RST  = 1'b0;

  // Ladder figures
  localparam logic [4:0] UNITS_RNG0  = 5'h1f;
  localparam logic [4:0] OFFSET_RNG0 = 5'h08;
  localparam logic [4:0] UNITS_RNG1  = 5'h17;

  // Synchroniser depth
  localparam int SYNC_STAGES = 2;

  // Edge or level sense selection
  typedef enum logic [1:0] {
    SENSE_LEVEL = 2'b00,
    SENSE_FALL  = 2'b01,
    SENSE_RISE  = 2'b10,
    SENSE_BOTH  = 2'b11
  } acc_sense_t;

  // Positive input source selection
  typedef enum logic [1:0] {
    SRC_PIN_A = 2'b00,
    SRC_PIN_B = 2'b01,
    SRC_REF   = 2'b10,
    SRC_RSVD  = 2'b11
  } acc_src_t;

endpackage

// ==== shared/acc_ev_if.sv ====
interface acc_ev_if;
  logic level;
  logic rise;
  logic fall;

  modport src (output level, rise, fall);
  modport dst (input  level, rise, fall);
endinterface

// ==== hw/acc_sync.sv ====
module acc_sync
  import acc_pkg::*;
#(
  parameter int STAGES = SYNC_STAGES
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Asynchronous comparator result
  input  wire logic async_in,
  // Synchronised level and edges
  acc_ev_if.src     ev
);

  logic [STAGES-1:0] sync_q;
  logic              prev_q;

  // Shift chain, first stage feeds only the next
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_q <= '0;
    end else begin
      sync_q <= {sync_q[STAGES-2:0], async_in};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= sync_q[STAGES-1];
    end
  end

  assign ev.level = sync_q[STAGES-1];
  assign ev.rise  = sync_q[STAGES-1] & ~prev_q;
  assign ev.fall  = ~sync_q[STAGES-1] & prev_q;

endmodule // acc_sync

// ==== hw/acc_ladder.sv ====
module acc_ladder
  import acc_pkg::*;
(
  // Ladder settings
  input  wire logic             enable,
  input  wire logic             range,
  input  wire logic [TAP_W-1:0] tap,
  // Reference code: numerator over total units
  output logic      [4:0]       numerator,
  output logic      [4:0]       units
);

  always_comb begin
    numerator = 5'h00;
    units     = UNITS_RNG1;
    if (enable && !range) begin
      numerator = {1'b0, tap} + OFFSET_RNG0;
      units     = UNITS_RNG0;
    end else if (enable) begin
      numerator = {1'b0, tap};
      units     = UNITS_RNG1;
    end
  end

endmodule // acc_ladder

// ==== hw/acc_top.sv ====
module acc_top
  import acc_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  // Analog comparator core
  input  wire logic              cmp_result,
  output logic                   pos_sel_pin,
  output logic                   pos_sel_ref,
  output logic                   neg_sel_pin,
  // Internal reference ladder
  output logic                   ladder_en,
  output logic                   ladder_range_bit,
  output logic      [TAP_W-1:0]  ladder_tap,
  output logic      [4:0]        ref_numerator,
  output logic      [4:0]        ref_units,
  // Output pin function
  output logic                   out_pin_drive_en,
  output logic                   out_pin_value,
  // Interrupt and converter trigger
  output logic                   irq,
  output logic                   adc_trigger
);

  acc_ev_if ev ();

  // Control fields
  logic             ctl_inv;
  acc_sense_t       ctl_isen;
  logic             ctl_islval;
  acc_sense_t       ctl_tsen;
  logic             ctl_tslval;
  acc_src_t         ctl_src;
  logic             ctl_ten;
  // Reference fields
  logic             ref_en;
  logic             ref_rng;
  logic [TAP_W-1:0] ref_tap;
  // Interrupt state
  logic             raw_irq;
  logic             irq_en;
  logic             next_raw_irq;
  logic             next_irq_en;
  // Event logic
  logic             output_value_bit;
  logic             rise_eff;
  logic             fall_eff;
  logic             int_event;
  logic             trig_event;
  logic             clr_hit;
  logic [4:0]       lad_num;
  logic [4:0]       lad_units;
  logic [DATA_W-1:0] next_rdata;

  acc_sync #(
    .STAGES   (SYNC_STAGES)
  ) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in (cmp_result),
    .ev       (ev)
  );

  acc_ladder u_ladder (
    .enable    (ref_en),
    .range     (ref_rng),
    .tap       (ref_tap),
    .numerator (lad_num),
    .units     (lad_units)
  );

  function automatic logic sense_hit(acc_sense_t s, logic lvl,
                                     logic val, logic r, logic f);
    logic hit;
    hit = 1'b0;
    case (s)
      SENSE_LEVEL: hit = (val == lvl);
      SENSE_FALL:  hit = f;
      SENSE_RISE:  hit = r;
      SENSE_BOTH:  hit = r | f;
      default:     hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Output value after optional inversion
  assign output_value_bit     = ev.level ^ ctl_inv;
  assign rise_eff = ctl_inv ? ev.fall : ev.rise;
  assign fall_eff = ctl_inv ? ev.rise : ev.fall;

  // Separate decisions for interrupt and trigger
  assign int_event  = sense_hit(ctl_isen, ctl_islval, output_value_bit,
                                rise_eff, fall_eff);
  assign trig_event = sense_hit(ctl_tsen, ctl_tslval, output_value_bit,
                                rise_eff, fall_eff);

  assign clr_hit = wr && (addr == OFF_MIS) && wdata[IRQ_BIT];

  // Control register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctl_inv    <= CTL_RST[CTL_INV_BIT];
      ctl_isen   <= acc_sense_t'(CTL_RST[CTL_ISEN_LSB +: 2]);
      ctl_islval <= CTL_RST[CTL_ISLVAL_BIT];
      ctl_tsen   <= acc_sense_t'(CTL_RST[CTL_TSEN_LSB +: 2]);
      ctl_tslval <= CTL_RST[CTL_TSLVAL_BIT];
      ctl_src    <= acc_src_t'(CTL_RST[CTL_SRC_LSB +: 2]);
      ctl_ten    <= CTL_RST[CTL_TEN_BIT];
    end else if (wr && addr == OFF_CTL) begin
      ctl_inv    <= wdata[CTL_INV_BIT];
      ctl_isen   <= acc_sense_t'(wdata[CTL_ISEN_LSB +: 2]);
      ctl_islval <= wdata[CTL_ISLVAL_BIT];
      ctl_tsen   <= acc_sense_t'(wdata[CTL_TSEN_LSB +: 2]);
      ctl_tslval <= wdata[CTL_TSLVAL_BIT];
      ctl_src    <= acc_src_t'(wdata[CTL_SRC_LSB +: 2]);
      ctl_ten    <= wdata[CTL_TEN_BIT];
    end
  end

  // Reference control register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ref_en  <= REFCTL_RST[REF_EN_BIT];
      ref_rng <= REFCTL_RST[REF_RNG_BIT];
      ref_tap <= REFCTL_RST[REF_TAP_LSB +: TAP_W];
    end else if (wr && addr == OFF_REFCTL) begin
      ref_en  <= wdata[REF_EN_BIT];
      ref_rng <= wdata[REF_RNG_BIT];
      ref_tap <= wdata[REF_TAP_LSB +: TAP_W];
    end
  end

  // Interrupt enable and sticky raw status; a new event beats a clear
  always_comb begin
    next_irq_en = irq_en;
    if (wr && addr == OFF_INTEN) begin
      next_irq_en = wdata[IRQ_BIT];
    end
    next_raw_irq = raw_irq;
    if (clr_hit) begin
      next_raw_irq = 1'b0;
    end
    if (int_event) begin
      next_raw_irq = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_en  <= INTEN_RST;
      raw_irq <= 1'b0;
    end else begin
      irq_en  <= next_irq_en;
      raw_irq <= next_raw_irq;
    end
  end

  // Interrupt request, high while enabled status is set
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= next_raw_irq & next_irq_en;
    end
  end

  // Converter trigger, one cycle per edge event or level while held
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      adc_trigger <= 1'b0;
    end else begin
      adc_trigger <= ctl_ten & trig_event;
    end
  end

  // Input routing to the analog core
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pos_sel_pin <= 1'b1;
      pos_sel_ref <= 1'b0;
      neg_sel_pin <= 1'b1;
    end else begin
      neg_sel_pin <= 1'b1;
      case (ctl_src)
        SRC_PIN_A, SRC_PIN_B: begin
          pos_sel_pin <= 1'b1;
          pos_sel_ref <= 1'b0;
        end
        SRC_REF: begin
          pos_sel_pin <= 1'b0;
          pos_sel_ref <= 1'b1;
        end
        default: begin
          pos_sel_pin <= 1'b0;
          pos_sel_ref <= 1'b0;
        end
      endcase
    end
  end

  // Ladder drive
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ladder_en        <= 1'b0;
      ladder_range_bit <= 1'b0;
      ladder_tap       <= '0;
      ref_numerator    <= 5'h00;
      ref_units        <= UNITS_RNG1;
    end else begin
      ladder_en        <= ref_en;
      ladder_range_bit <= ref_rng;
      ladder_tap       <= ref_tap;
      ref_numerator    <= lad_num;
      ref_units        <= lad_units;
    end
  end

  // Comparator never drives a pin, so the pad stays plain GPIO
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_pin_drive_en <= 1'b0;
      out_pin_value    <= 1'b0;
    end else begin
      out_pin_drive_en <= 1'b0;
      out_pin_value    <= 1'b0;
    end
  end

  // Read data, one cycle after the read strobe
  always_comb begin
    next_rdata = '0;
    case (addr)
      OFF_MIS:    next_rdata[IRQ_BIT] = raw_irq & irq_en;
      OFF_RIS:    next_rdata[IRQ_BIT] = raw_irq;
      OFF_INTEN:  next_rdata[IRQ_BIT] = irq_en;
      OFF_REFCTL: begin
        next_rdata[REF_EN_BIT]             = ref_en;
        next_rdata[REF_RNG_BIT]            = ref_rng;
        next_rdata[REF_TAP_LSB +: TAP_W]   = ref_tap;
      end
      OFF_STAT:   next_rdata[STAT_OUTPUT_VALUE_BIT_BIT] = output_value_bit;
      OFF_CTL: begin
        next_rdata[CTL_INV_BIT]            = ctl_inv;
        next_rdata[CTL_ISEN_LSB +: 2]      = ctl_isen;
        next_rdata[CTL_ISLVAL_BIT]         = ctl_islval;
        next_rdata[CTL_TSEN_LSB +: 2]      = ctl_tsen;
        next_rdata[CTL_TSLVAL_BIT]         = ctl_tslval;
        next_rdata[CTL_SRC_LSB +: 2]       = ctl_src;
        next_rdata[CTL_TEN_BIT]            = ctl_ten;
      end
      default:    next_rdata = '0;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= '0;
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sync_depth_a: assert property (
    ##2 (ev.level == $past(cmp_result, 2)))
    else $error("level is not the input two cycles back");

  stat_read_a: assert property (
    (rd && addr == OFF_STAT) |=>
      (rdata[STAT_OUTPUT_VALUE_BIT_BIT] == $past(output_value_bit)))
    else $error("status read does not show output value");

  raw_sticky_a: assert property (
    (raw_irq && !clr_hit) |=> raw_irq)
    else $error("raw status dropped without a clear");

  clear_one_a: assert property (
    (clr_hit && !int_event) |=> !raw_irq)
    else $error("write of one did not clear status");

  set_wins_a: assert property (
    int_event |=> (raw_irq ##1 (raw_irq || $past(clr_hit))))
    else $error("event lost against a clear");

  irq_gate_a: assert property (
    ##1 (irq == (raw_irq & irq_en)))
    else $error("interrupt not equal to enabled status");

  neg_pin_a: assert property (
    neg_sel_pin)
    else $error("negative input left the external pin");

  src_route_a: assert property (
    (ctl_src == SRC_REF) |=> (pos_sel_ref && !pos_sel_pin))
    else $error("reference source not routed");

  src_pin_a: assert property (
    (ctl_src == SRC_PIN_A || ctl_src == SRC_PIN_B) |=>
      (pos_sel_pin && !pos_sel_ref))
    else $error("pin source not routed");

  no_pin_a: assert property (
    !out_pin_drive_en)
    else $error("comparator drove an output pin");

  range_zero_a: assert property (
    (ref_en && !ref_rng) |=>
      (ref_numerator == 5'($past(ref_tap) + 5'h08) &&
       ref_units == 5'h1f))
    else $error("range zero reference code wrong");

  range_one_a: assert property (
    (ref_en && ref_rng) |=>
      (ref_numerator == {1'b0, $past(ref_tap)} && ref_units == 5'h17))
    else $error("range one reference code wrong");

  ladder_off_a: assert property (
    !ref_en |=> (ref_numerator == 5'h00 && !ladder_en))
    else $error("disabled ladder not at ground");

  split_edge_a: assert property (
    (ctl_ten && ctl_tsen == SENSE_FALL && ctl_isen == SENSE_RISE &&
     fall_eff) |=> (adc_trigger && !$past(int_event)))
    else $error("trigger and interrupt edges not independent");

  irq_rise_c: cover property (
    (ctl_isen == SENSE_RISE && irq_en) ##1 rise_eff ##2 irq);

  trig_fall_c: cover property (
    ctl_ten && ctl_tsen == SENSE_FALL && fall_eff ##1 adc_trigger);

  clear_c: cover property (
    raw_irq ##1 clr_hit ##1 !raw_irq);

  set_clear_c: cover property (
    (clr_hit && int_event) ##1 raw_irq);

endmodule // acc_top

// ==== verification/acc_analog_model.sv ====
module acc_analog_model
  import acc_pkg::*;
#(
  parameter int AVDD_MV = 3300
) (
  // Routing and ladder code from the block
  input  wire logic        pos_sel_pin,
  input  wire logic        pos_sel_ref,
  input  wire logic        neg_sel_pin,
  input  wire logic        ladder_en,
  input  wire logic [4:0]  ref_numerator,
  input  wire logic [4:0]  ref_units,
  // Pin voltages in millivolts
  input  wire logic [15:0] pos_mv,
  input  wire logic [15:0] neg_mv,
  // Comparator core output
  output logic             cmp_result
);
  timeunit 1ns;
  timeprecision 1ps;

  int vref_mv;
  int vin_pos;
  int vin_neg;

  always_comb begin
    vref_mv = 0;
    if (ladder_en && ref_units != 5'h00) begin
      vref_mv = AVDD_MV * int'(ref_numerator) / int'(ref_units);
    end
    // Nothing routed: positive node pulled to ground
    vin_pos = 0;
    if (pos_sel_pin) begin
      vin_pos = int'(pos_mv);
    end else if (pos_sel_ref) begin
      vin_pos = vref_mv;
    end
    vin_neg = neg_sel_pin ? int'(neg_mv) : 0;
  end

  assign cmp_result = (vin_neg < vin_pos);
endmodule // acc_analog_model

// ==== verification/analog_comparator_control_bench.sv ====
module analog_comparator_control_bench
  import acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clock;
  logic              rst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              cmp_result;
  logic              pos_sel_pin;
  logic              pos_sel_ref;
  logic              neg_sel_pin;
  logic              ladder_en;
  logic              ladder_range_bit;
  logic [TAP_W-1:0]  ladder_tap;
  logic [4:0]        ref_numerator;
  logic [4:0]        ref_units;
  logic              out_pin_drive_en;
  logic              out_pin_value;
  logic              irq;
  logic              adc_trigger;
  logic [15:0]       pos_mv;
  logic [15:0]       neg_mv;
  int                num_errors;
  int                n_tests;
  int                trig_cnt;

  acc_top acc_top_i (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .cmp_result(cmp_result),
    .pos_sel_pin(pos_sel_pin), .pos_sel_ref(pos_sel_ref),
    .neg_sel_pin(neg_sel_pin), .ladder_en(ladder_en),
    .ladder_range_bit(ladder_range_bit), .ladder_tap(ladder_tap),
    .ref_numerator(ref_numerator), .ref_units(ref_units),
    .out_pin_drive_en(out_pin_drive_en), .out_pin_value(out_pin_value),
    .irq(irq), .adc_trigger(adc_trigger)
  );

  acc_analog_model acc_analog_model_i (
    .pos_sel_pin(pos_sel_pin), .pos_sel_ref(pos_sel_ref),
    .neg_sel_pin(neg_sel_pin), .ladder_en(ladder_en),
    .ref_numerator(ref_numerator), .ref_units(ref_units),
    .pos_mv(pos_mv), .neg_mv(neg_mv), .cmp_result(cmp_result)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Cycles with the converter trigger high
  always @(posedge clock) begin
    if (adc_trigger === 1'b1) trig_cnt++;
  end

  task automatic final_report();
    if (num_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic set_neg(input logic [15:0] v);
    @(posedge clock);
    neg_mv <= v;
  endtask

  task automatic test_reset();
    chk(32'(neg_sel_pin), 32'h1);
    chk(32'({out_pin_drive_en, out_pin_value}), 32'h0);
    rd_chk(OFF_REFCTL, 32'h0);
    rd_chk(OFF_CTL, 32'h0);
    rd_chk(OFF_INTEN, 32'h0);
    rd_chk(OFF_MIS, 32'h0);
    wr_reg(12'h00c, 32'hffff_ffff);
    rd_chk(12'h00c, 32'h0);
  endtask

  task automatic test_ladder();
    logic [31:0] vals [4];
    logic [31:0] d;
    logic [4:0]  num;
    vals = '{32'h0000_030c, 32'h0000_020f, 32'h0000_010c, 32'h0000_0100};
    for (int i = 0; i < 4; i++) begin
      d = vals[i];
      wr_reg(OFF_REFCTL, d | 32'hffff_fcf0);
      wait_clk(3);
      num = d[9] ? (d[8] ? 5'(d[3:0]) : 5'(d[3:0]) + 5'h08) : 5'h00;
      chk(32'(ref_numerator), 32'(num));
      chk(32'(ref_units), d[8] ? 32'h17 : 32'h1f);
      chk(32'({ladder_en, ladder_range_bit, ladder_tap}),
          32'({d[9], d[8], d[3:0]}));
      rd_chk(OFF_REFCTL, d);
    end
  endtask

  task automatic test_source();
    logic [1:0] sel;
    @(posedge clock);
    pos_mv <= 16'h07d0;
    neg_mv <= 16'h03e8;
    for (int c = 0; c < 4; c++) begin
      wr_reg(OFF_CTL, 32'(c) << CTL_SRC_LSB);
      wait_clk(5);
      sel = (c < 2) ? 2'b10 : (c == 2) ? 2'b01 : 2'b00;
      chk(32'({pos_sel_pin, pos_sel_ref}), 32'(sel));
      chk(32'({neg_sel_pin, out_pin_drive_en}), 32'h2);
      rd_chk(OFF_STAT, (c < 2) ? 32'h2 : 32'h0);
    end
  endtask

  task automatic test_events();
    int t0;
    wr_reg(OFF_REFCTL, 32'h0000_030c);
    set_neg(16'h09c4);
    // Reference source, rising edge interrupt, falling edge trigger
    wr_reg(OFF_CTL, 32'h0000_0c28);
    wait_clk(5);
    rd_chk(OFF_STAT, 32'h0);
    wr_reg(OFF_MIS, 32'h1);
    wr_reg(OFF_INTEN, 32'h1);
    wait_clk(2);
    rd_chk(OFF_RIS, 32'h0);
    chk(32'(irq), 32'h0);
    t0 = trig_cnt;
    set_neg(16'h03e8);
    wait_clk(5);
    chk(32'(irq), 32'h1);
    chk(32'(trig_cnt), 32'(t0));
    rd_chk(OFF_STAT, 32'h2);
    set_neg(16'h09c4);
    wait_clk(5);
    chk(32'(trig_cnt), 32'(t0 + 1));
    chk(32'(irq), 32'h1);
    wr_reg(OFF_MIS, 32'h0);
    wait_clk(2);
    chk(32'(irq), 32'h1);
    wr_reg(OFF_INTEN, 32'h0);
    wait_clk(2);
    chk(32'(irq), 32'h0);
    rd_chk(OFF_RIS, 32'h1);
    rd_chk(OFF_MIS, 32'h0);
    wr_reg(OFF_MIS, 32'h1);
    wait_clk(2);
    rd_chk(OFF_RIS, 32'h0);
  endtask

  task automatic test_modes();
    int t0;
    t0 = trig_cnt;
    // Internal reference, both edges interrupt, trigger off
    wr_reg(OFF_CTL, 32'h0000_040c);
    wait_clk(2);
    chk(32'({pos_sel_pin, pos_sel_ref}), 32'h1);
    rd_chk(OFF_CTL, 32'h0000_040c);
    wr_reg(OFF_INTEN, 32'h1);
    set_neg(16'h03e8);
    wait_clk(5);
    rd_chk(OFF_MIS, 32'h1);
    wr_reg(OFF_MIS, 32'h1);
    wait_clk(2);
    chk(32'(irq), 32'h0);
    set_neg(16'h09c4);
    wait_clk(5);
    chk(32'(irq), 32'h1);
    chk(32'(trig_cnt), 32'(t0));
    wr_reg(OFF_MIS, 32'h1);
    // Inverted output, trigger while value high, interrupt while low
    wr_reg(OFF_CTL, 32'h0000_0c82);
    wait_clk(4);
    rd_chk(OFF_STAT, 32'h2);
    chk(32'({adc_trigger, irq}), 32'h2);
    set_neg(16'h03e8);
    wait_clk(5);
    chk(32'({adc_trigger, irq}), 32'h1);
    rd_chk(OFF_STAT, 32'h0);
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    final_report();
  end

  initial begin
    num_errors = 0;
    n_tests    = 0;
    trig_cnt   = 0;
    rst        = 1'b1;
    addr       = '0;
    wdata      = '0;
    wr         = 1'b0;
    rd         = 1'b0;
    pos_mv     = 16'h0000;
    neg_mv     = 16'h09c4;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    wait_clk(1);
    test_reset();
    test_ladder();
    test_source();
    test_events();
    test_modes();
    final_report();
  end
endmodule // analog_comparator_control_bench
